// File: rtl/bcrc_map.vh
// constants of the brake and current reduction controller
// Overview of operation
// R01: A reduction setting from zero up to below the rated current is the standstill current in mA RMS.
// R02: A setting from -1 to -100 gives rated current times (setting + 100) / 100, so -100 gives zero.
// R03: After standstill the close-brake idle time, default 1000 ms, passes before the brake engages.
// R04: After the brake engages the shutdown idle time passes before motor current is switched off.
// R05: On enable the motor current comes on first and the brake opens after the open-brake delay.
// R06: After the brake opens the start-operation delay, default zero, passes before operation enabled.
// R07: All four brake delays count in milliseconds and sit with PWM frequency and duty in one group.
// R08: The brake PWM runs at the programmed frequency in hertz, settings 0 to 2000 accepted.
// R09: The brake PWM uses the programmed duty in percent, only 0 or 2 through 100 accepted.
// R10: Reported motor currents are peak values in mA, square root of two times the RMS value.
// R11: Four read-only signed 32-bit readings: field, torque, phase A and phase B currents.
// R12: Current reduction applies only while the reduction enable bit is set and the motor stands still.
// R13: The motor must stand still for the standstill idle time, default 1000 ms, before reduction.
// R14: Field and torque currents read as zero unless closed-loop control is active.
// R15: A one-millisecond tick from the system clock drives every delay counter and the idle timer.
// R16: The brake PWM output stays inactive whenever frequency or duty setting is zero.
`ifndef BCRC_MAP_VH
`define BCRC_MAP_VH
`define BCRC_CLK_HZ 25000000
`define BCRC_TICK_US 1000
`define BCRC_TICK_CYCLES (`BCRC_CLK_HZ / 1000000 * `BCRC_TICK_US)
`define BCRC_IDX_REDUCTION 16'h2037
`define BCRC_IDX_BRAKE 16'h2038
`define BCRC_IDX_CURRENTS 16'h2039
`define BCRC_SUB_COUNT 8'h00
`define BCRC_SUB_CLOSE_IDLE 8'h01
`define BCRC_SUB_POWER_OFF 8'h02
`define BCRC_SUB_OPEN_DELAY 8'h03
`define BCRC_SUB_START_DELAY 8'h04
`define BCRC_SUB_PWM_FREQ 8'h05
`define BCRC_SUB_PWM_DUTY 8'h06
`define BCRC_SUB_FIELD 8'h01
`define BCRC_SUB_TORQUE 8'h02
`define BCRC_SUB_PHASE_A 8'h03
`define BCRC_SUB_PHASE_B 8'h04
`define BCRC_RST_REDUCTION 32'h0fffffce
`define BCRC_RST_BRAKE_COUNT 8'h06
`define BCRC_RST_CLOSE_IDLE 32'h000003e8
`define BCRC_RST_POWER_OFF 32'h000003e8
`define BCRC_RST_OPEN_DELAY 32'h000003e8
`define BCRC_RST_START_DELAY 32'h00000000
`define BCRC_RST_PWM_FREQ 32'h00000000
`define BCRC_RST_PWM_DUTY 32'h00000000
`define BCRC_RST_CURRENT_COUNT 8'h04
`define BCRC_PWM_FREQ_MAX 32'h000007d0
`define BCRC_PWM_DUTY_MIN 32'h00000002
`define BCRC_PWM_DUTY_MAX 32'h00000064
`define BCRC_PCT_MIN 32'hffffff9c
`define BCRC_PCT_FULL 40'h0000000064
`define BCRC_ENABLE_BIT 3
`define BCRC_SQRT2_Q15 48'h00000000b505
`define BCRC_SQRT2_SHIFT 15
`endif

// File: rtl/bcrc_pwm.v
// software-style brake pwm with 1 % duty resolution
`include "bcrc_map.vh"
`default_nettype none
module bcrc_pwm #(
  parameter CLK_HZ = `BCRC_CLK_HZ
) (
  // clock and reset
  input wire clk,
  input wire reset,
  input wire clkEnable,
  // control
  input wire run,
  input wire [31:0] frequency,
  input wire [31:0] duty,
  // brake drive
  output reg pwmOut
);
  localparam [31:0] ACC_LIMIT = CLK_HZ;
  localparam [6:0] LAST_STEP = 7'h63;
  reg [31:0] acc_reg;
  reg [6:0] step_reg;
  wire [31:0] accStep;
  wire [31:0] accSum;
  wire active;
  // hundred steps per period, so step rate is frequency * 100
  assign accStep = frequency * 32'h00000064; // R08
  assign accSum = acc_reg + accStep;
  // zero setting in either field keeps the brake drive off
  assign active = run && (frequency != 32'h0) && (duty != 32'h0); // R16
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      acc_reg <= 32'h0;
      step_reg <= 7'h0;
      pwmOut <= 1'b0;
    end else if (clkEnable) begin
      if (!active) begin
        acc_reg <= 32'h0;
        step_reg <= 7'h0;
        pwmOut <= 1'b0; // R16
      end else begin
        if (accSum >= ACC_LIMIT) begin
          acc_reg <= accSum - ACC_LIMIT;
          step_reg <= (step_reg == LAST_STEP) ? 7'h0 : step_reg + 7'h1; // R08
        end else begin
          acc_reg <= accSum;
        end
        pwmOut <= ({25'h0, step_reg} < duty); // R09
      end
    end
  end
endmodule
`default_nettype wire

// File: rtl/bcrc_ctl.v
// brake sequencing, standstill current reduction and current readout
`include "bcrc_map.vh"
`default_nettype none
module bcrc_ctl #(
  parameter CLK_HZ = `BCRC_CLK_HZ,
  parameter TICK_CYCLES = `BCRC_TICK_CYCLES
) (
  // clock and reset
  input wire clk,
  input wire reset,
  input wire clkEnable,
  // object dictionary access
  input wire [15:0] odIndex,
  input wire [7:0] odSubindex,
  input wire odWrite,
  input wire odRead,
  input wire [31:0] odWriteData,
  output reg [31:0] odReadData,
  output reg odAck,
  output reg odError,
  // drive settings from neighbouring objects
  input wire [31:0] ratedCurrentSetting,
  input wire [31:0] motorDriveOptionWord,
  input wire [31:0] standstillIdleTime,
  // drive status
  input wire enableRequest,
  input wire motorStandstill,
  input wire closedLoopActive,
  // measured currents, rms mA, signed
  input wire [31:0] fieldCurrentRms,
  input wire [31:0] torqueCurrentRms,
  input wire [31:0] phaseACurrentRms,
  input wire [31:0] phaseBCurrentRms,
  // motor and brake
  output reg [31:0] currentSetpoint,
  output reg reductionActive,
  output wire motorPowerOn,
  output wire brakeOpen,
  output wire brakePwm,
  output wire operationEnabled
);
  localparam [5:0] ST_OFF = 6'h01;
  localparam [5:0] ST_POWER_UP = 6'h02;
  localparam [5:0] ST_START_WAIT = 6'h04;
  localparam [5:0] ST_RUN = 6'h08;
  localparam [5:0] ST_CLOSE_WAIT = 6'h10;
  localparam [5:0] ST_POWER_DOWN = 6'h20;
  localparam [31:0] TICK_LAST = TICK_CYCLES - 1;

  function [31:0] toPeak;
    input [31:0] rms;
    reg [47:0] prod;
    begin
      prod = $signed({{16{rms[31]}}, rms}) * $signed(`BCRC_SQRT2_Q15);
      toPeak = prod[`BCRC_SQRT2_SHIFT + 31:`BCRC_SQRT2_SHIFT];
    end
  endfunction

  function [31:0] reducedCurrent;
    input [31:0] setting;
    input [31:0] rated;
    reg [39:0] scaled;
    reg [31:0] pct;
    begin
      pct = setting + 32'h00000064;
      scaled = ({8'h0, rated} * {8'h0, pct}) / `BCRC_PCT_FULL;
      if (!setting[31] && setting < rated) begin
        reducedCurrent = setting; // R01
      end else if (setting[31] && setting >= `BCRC_PCT_MIN) begin
        reducedCurrent = scaled[31:0]; // R02
      end else begin
        reducedCurrent = rated;
      end
    end
  endfunction

  // settings
  reg [31:0] reductionSetting_reg;
  reg [31:0] closeIdle_reg;
  reg [31:0] powerOffIdle_reg;
  reg [31:0] openDelay_reg;
  reg [31:0] startDelay_reg;
  reg [31:0] pwmFreq_reg;
  reg [31:0] pwmDuty_reg;
  // timing
  reg [31:0] tickCount_reg;
  reg msTick_reg;
  reg [31:0] seqMs_reg;
  reg [31:0] idleMs_reg;
  reg [5:0] state_reg;
  reg [5:0] state_next;
  reg [31:0] seqTarget;
  // readings
  reg [31:0] fieldPeak_reg;
  reg [31:0] torquePeak_reg;
  reg [31:0] phaseAPeak_reg;
  reg [31:0] phaseBPeak_reg;
  // access decode
  reg [31:0] readValue;
  reg readHit;
  reg writeOk;
  wire seqDone;
  wire idleDone;
  wire reductionEnable;

  // millisecond time base
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      tickCount_reg <= 32'h0;
      msTick_reg <= 1'b0;
    end else if (clkEnable) begin
      if (tickCount_reg >= TICK_LAST) begin
        tickCount_reg <= 32'h0;
        msTick_reg <= 1'b1; // R15
      end else begin
        tickCount_reg <= tickCount_reg + 32'h1;
        msTick_reg <= 1'b0;
      end
    end
  end

  // brake sequence
  always @* begin
    case (state_reg)
      ST_POWER_UP: seqTarget = openDelay_reg; // R05
      ST_START_WAIT: seqTarget = startDelay_reg; // R06
      ST_CLOSE_WAIT: seqTarget = closeIdle_reg; // R03
      ST_POWER_DOWN: seqTarget = powerOffIdle_reg; // R04
      default: seqTarget = 32'h0;
    endcase
  end
  // a tick may land right after entry, so one more tick keeps the full delay
  assign seqDone = (seqTarget == 32'h0) || (seqMs_reg > seqTarget); // R07

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF: begin
        if (enableRequest) begin
          state_next = ST_POWER_UP; // R05
        end
      end
      ST_POWER_UP: begin
        if (!enableRequest) begin
          state_next = ST_OFF;
        end else if (seqDone) begin
          state_next = ST_START_WAIT; // R05
        end
      end
      ST_START_WAIT: begin
        if (!enableRequest) begin
          state_next = ST_CLOSE_WAIT;
        end else if (seqDone) begin
          state_next = ST_RUN; // R06
        end
      end
      ST_RUN: begin
        if (!enableRequest) begin
          state_next = ST_CLOSE_WAIT;
        end
      end
      ST_CLOSE_WAIT: begin
        if (enableRequest) begin
          state_next = ST_RUN;
        end else if (motorStandstill && seqDone) begin
          state_next = ST_POWER_DOWN; // R03
        end
      end
      ST_POWER_DOWN: begin
        if (seqDone) begin
          state_next = ST_OFF; // R04
        end
      end
      default: state_next = ST_OFF;
    endcase
  end

  // close-idle time only runs once the shaft has stopped
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= ST_OFF;
      seqMs_reg <= 32'h0;
    end else if (clkEnable) begin
      state_reg <= state_next;
      if (state_next != state_reg) begin
        seqMs_reg <= 32'h0;
      end else if (state_reg == ST_CLOSE_WAIT && !motorStandstill) begin
        seqMs_reg <= 32'h0; // R03
      end else if (msTick_reg && !seqDone) begin
        seqMs_reg <= seqMs_reg + 32'h1; // R15
      end
    end
  end

  assign motorPowerOn = !state_reg[0]; // R05
  assign brakeOpen = state_reg[2] | state_reg[3] | state_reg[4]; // R04
  assign operationEnabled = state_reg[3]; // R06

  bcrc_pwm #(
    .CLK_HZ(CLK_HZ)
  ) brakeDrive (
    .clk(clk),
    .reset(reset),
    .clkEnable(clkEnable),
    .run(brakeOpen),
    .frequency(pwmFreq_reg),
    .duty(pwmDuty_reg),
    .pwmOut(brakePwm)
  );

  // standstill idle timer and reduced current
  assign reductionEnable = motorDriveOptionWord[`BCRC_ENABLE_BIT];
  assign idleDone = (standstillIdleTime == 32'h0) || (idleMs_reg > standstillIdleTime); // R13

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      idleMs_reg <= 32'h0;
      reductionActive <= 1'b0;
      currentSetpoint <= 32'h0;
    end else if (clkEnable) begin
      if (!(reductionEnable && motorStandstill)) begin
        idleMs_reg <= 32'h0; // R12
      end else if (msTick_reg && !idleDone) begin
        idleMs_reg <= idleMs_reg + 32'h1; // R15
      end
      reductionActive <= reductionEnable && motorStandstill && idleDone && motorPowerOn; // R12
      if (!motorPowerOn) begin
        currentSetpoint <= 32'h0;
      end else if (reductionEnable && motorStandstill && idleDone) begin
        currentSetpoint <= reducedCurrent(reductionSetting_reg, ratedCurrentSetting); // R13
      end else begin
        currentSetpoint <= ratedCurrentSetting;
      end
    end
  end

  // readings held as peak values
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      fieldPeak_reg <= 32'h0;
      torquePeak_reg <= 32'h0;
      phaseAPeak_reg <= 32'h0;
      phaseBPeak_reg <= 32'h0;
    end else if (clkEnable) begin
      fieldPeak_reg <= closedLoopActive ? toPeak(fieldCurrentRms) : 32'h0; // R14
      torquePeak_reg <= closedLoopActive ? toPeak(torqueCurrentRms) : 32'h0; // R14
      phaseAPeak_reg <= toPeak(phaseACurrentRms); // R10
      phaseBPeak_reg <= toPeak(phaseBCurrentRms); // R10
    end
  end

  // read decode
  always @* begin
    readValue = 32'h0;
    readHit = 1'b1;
    if (odIndex == `BCRC_IDX_REDUCTION && odSubindex == `BCRC_SUB_COUNT) begin
      readValue = reductionSetting_reg;
    end else if (odIndex == `BCRC_IDX_BRAKE) begin
      case (odSubindex)
        `BCRC_SUB_COUNT: readValue = {24'h0, `BCRC_RST_BRAKE_COUNT}; // R07
        `BCRC_SUB_CLOSE_IDLE: readValue = closeIdle_reg;
        `BCRC_SUB_POWER_OFF: readValue = powerOffIdle_reg;
        `BCRC_SUB_OPEN_DELAY: readValue = openDelay_reg;
        `BCRC_SUB_START_DELAY: readValue = startDelay_reg;
        `BCRC_SUB_PWM_FREQ: readValue = pwmFreq_reg;
        `BCRC_SUB_PWM_DUTY: readValue = pwmDuty_reg;
        default: readHit = 1'b0;
      endcase
    end else if (odIndex == `BCRC_IDX_CURRENTS) begin
      case (odSubindex)
        `BCRC_SUB_COUNT: readValue = {24'h0, `BCRC_RST_CURRENT_COUNT}; // R11
        `BCRC_SUB_FIELD: readValue = fieldPeak_reg; // R11
        `BCRC_SUB_TORQUE: readValue = torquePeak_reg;
        `BCRC_SUB_PHASE_A: readValue = phaseAPeak_reg;
        `BCRC_SUB_PHASE_B: readValue = phaseBPeak_reg;
        default: readHit = 1'b0;
      endcase
    end else begin
      readHit = 1'b0;
    end
  end

  // write checks: out-of-range pwm values are refused, not clipped
  always @* begin
    writeOk = 1'b0;
    if (odIndex == `BCRC_IDX_REDUCTION && odSubindex == `BCRC_SUB_COUNT) begin
      writeOk = 1'b1;
    end else if (odIndex == `BCRC_IDX_BRAKE) begin
      case (odSubindex)
        `BCRC_SUB_CLOSE_IDLE: writeOk = 1'b1;
        `BCRC_SUB_POWER_OFF: writeOk = 1'b1;
        `BCRC_SUB_OPEN_DELAY: writeOk = 1'b1;
        `BCRC_SUB_START_DELAY: writeOk = 1'b1;
        `BCRC_SUB_PWM_FREQ: writeOk = (odWriteData <= `BCRC_PWM_FREQ_MAX); // R08
        `BCRC_SUB_PWM_DUTY: writeOk = (odWriteData == 32'h0) ||
          (odWriteData >= `BCRC_PWM_DUTY_MIN && odWriteData <= `BCRC_PWM_DUTY_MAX); // R09
        default: writeOk = 1'b0;
      endcase
    end
  end

  // register file
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      reductionSetting_reg <= `BCRC_RST_REDUCTION;
      closeIdle_reg <= `BCRC_RST_CLOSE_IDLE;
      powerOffIdle_reg <= `BCRC_RST_POWER_OFF;
      openDelay_reg <= `BCRC_RST_OPEN_DELAY;
      startDelay_reg <= `BCRC_RST_START_DELAY;
      pwmFreq_reg <= `BCRC_RST_PWM_FREQ;
      pwmDuty_reg <= `BCRC_RST_PWM_DUTY;
      odReadData <= 32'h0;
      odAck <= 1'b0;
      odError <= 1'b0;
    end else if (clkEnable) begin
      odAck <= 1'b0;
      odError <= 1'b0;
      if (odWrite) begin
        odAck <= writeOk;
        odError <= !writeOk;
        if (writeOk) begin
          if (odIndex == `BCRC_IDX_REDUCTION) begin
            reductionSetting_reg <= odWriteData;
          end else begin
            case (odSubindex)
              `BCRC_SUB_CLOSE_IDLE: closeIdle_reg <= odWriteData; // R07
              `BCRC_SUB_POWER_OFF: powerOffIdle_reg <= odWriteData;
              `BCRC_SUB_OPEN_DELAY: openDelay_reg <= odWriteData;
              `BCRC_SUB_START_DELAY: startDelay_reg <= odWriteData;
              `BCRC_SUB_PWM_FREQ: pwmFreq_reg <= odWriteData;
              `BCRC_SUB_PWM_DUTY: pwmDuty_reg <= odWriteData;
              default: pwmDuty_reg <= pwmDuty_reg;
            endcase
          end
        end
      end else if (odRead) begin
        odAck <= readHit;
        odError <= !readHit;
        odReadData <= readHit ? readValue : 32'h0;
      end
    end
  end
endmodule
`default_nettype wire

// File: testbench/bcrc_ctl_properties.sv
// port assertions for the brake and current reduction controller
`default_nettype none
module bcrc_ctl_properties #(
  parameter CLK_HZ = 25000000,
  parameter TICK_CYCLES = 25000
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic clkEnable,
  // object access
  input wire logic [15:0] odIndex,
  input wire logic [7:0] odSubindex,
  input wire logic odWrite,
  input wire logic odRead,
  input wire logic [31:0] odWriteData,
  input wire logic [31:0] odReadData,
  input wire logic odAck,
  input wire logic odError,
  // drive status
  input wire logic [31:0] motorDriveOptionWord,
  input wire logic motorStandstill,
  input wire logic closedLoopActive,
  // motor and brake
  input wire logic reductionActive,
  input wire logic motorPowerOn,
  input wire logic brakeOpen,
  input wire logic brakePwm,
  input wire logic operationEnabled
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic req, wrB, rdDq;
  assign req = clkEnable && (odWrite || odRead);
  assign wrB = clkEnable && odWrite && odIndex == 16'h2038;
  assign rdDq = req && !odWrite && odIndex == 16'h2039 && odSubindex inside {8'h01, 8'h02};
  property p_one_answer;
    req |=> odAck != odError;
  endproperty
  a_one_answer: assert property (p_one_answer) else $error("request not answered once");
  property p_no_stray;
    odAck || odError |-> $past(req);
  endproperty
  a_no_stray: assert property (p_no_stray) else $error("answer without request");
  property p_freq;
    wrB && odSubindex == 8'h05 |=> odError == $past(odWriteData > 32'h000007d0);
  endproperty
  a_freq: assert property (p_freq) else $error("frequency limit wrong");
  property p_duty;
    wrB && odSubindex == 8'h06 |=>
      odError == $past(odWriteData == 32'h00000001 || odWriteData > 32'h00000064);
  endproperty
  a_duty: assert property (p_duty) else $error("duty limit wrong");
  property p_open_after_power;
    $rose(brakeOpen) |-> motorPowerOn && $past(motorPowerOn);
  endproperty
  a_open_after_power: assert property (p_open_after_power) else $error("brake opened early");
  property p_run_needs_brake;
    operationEnabled |-> brakeOpen && motorPowerOn;
  endproperty
  a_run_needs_brake: assert property (p_run_needs_brake) else $error("run with brake shut");
  property p_close_standstill;
    $fell(brakeOpen) |-> $past(motorStandstill);
  endproperty
  a_close_standstill: assert property (p_close_standstill) else $error("closed while moving");
  property p_off_after_close;
    $fell(motorPowerOn) |-> !$past(brakeOpen);
  endproperty
  a_off_after_close: assert property (p_off_after_close) else $error("power off, brake open");
  property p_pwm_quiet;
    !brakeOpen && !$past(brakeOpen) |-> !brakePwm;
  endproperty
  a_pwm_quiet: assert property (p_pwm_quiet) else $error("pwm active, brake closed");
  property p_dq_zero;
    rdDq && !closedLoopActive && !$past(closedLoopActive) |=> odReadData == 32'h00000000;
  endproperty
  a_dq_zero: assert property (p_dq_zero) else $error("dq current not zero");
  property p_reduce_cond;
    reductionActive |-> $past(motorStandstill && motorDriveOptionWord[3]);
  endproperty
  a_reduce_cond: assert property (p_reduce_cond) else $error("reduction out of standstill");
  c_run: cover property ($rose(operationEnabled));
  c_reduce: cover property ($rose(reductionActive));
  c_pwm: cover property ($rose(brakePwm));
  c_refuse: cover property (odError);
endmodule
bind bcrc_ctl bcrc_ctl_properties #(.CLK_HZ(CLK_HZ), .TICK_CYCLES(TICK_CYCLES)) uProps (
  .clk(clk), .reset(reset), .clkEnable(clkEnable), .odIndex(odIndex),
  .odSubindex(odSubindex), .odWrite(odWrite), .odRead(odRead), .odWriteData(odWriteData),
  .odReadData(odReadData), .odAck(odAck), .odError(odError),
  .motorDriveOptionWord(motorDriveOptionWord), .motorStandstill(motorStandstill),
  .closedLoopActive(closedLoopActive), .reductionActive(reductionActive),
  .motorPowerOn(motorPowerOn), .brakeOpen(brakeOpen), .brakePwm(brakePwm),
  .operationEnabled(operationEnabled));
`default_nettype wire

// File: testbench/bcrc_motor_model.sv
// motor model: standstill sensing and phase currents
`default_nettype none
module bcrc_motor_model (
  // bench command
  input wire logic moving,
  // drive outputs
  input wire logic motorPowerOn,
  input wire logic [31:0] currentSetpoint,
  // sensed values
  output logic motorStandstill,
  output logic [31:0] phaseACurrentRms,
  output logic [31:0] phaseBCurrentRms
);
  timeunit 1ns;
  timeprecision 1ns;
  // opposite phase sign exercises negative readings
  assign motorStandstill = !moving;
  assign phaseACurrentRms = motorPowerOn ? currentSetpoint : 32'h0;
  assign phaseBCurrentRms = motorPowerOn ? -currentSetpoint : 32'h0;
endmodule
`default_nettype wire

// File: testbench/bcrc_ctl_tb.sv
// self-checking bench for the brake and current reduction controller
`default_nettype none
module bcrc_ctl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TICK = 10;
  logic clk = 1'b0, reset = 1'b1, clkEnable = 1'b1, odWrite = 1'b0, odRead = 1'b0;
  logic [15:0] odIndex = 16'h0;
  logic [7:0] odSubindex = 8'h0;
  logic [31:0] odWriteData = 32'h0, rated = 32'h00001068, optWord = 32'h0, fRms = 32'h0;
  logic [31:0] qRms = 32'h0, phA, phB, setpoint, odReadData, rd, v;
  logic odAck, odError, enReq = 1'b0, standstill, closedLoop = 1'b0, moving = 1'b1;
  logic reductionActive, motorPowerOn, brakeOpen, brakePwm, operationEnabled;
  int n_mismatch = 0, num_checks = 0, cyc = 0, n, hi, rises;
  logic [55:0] defs [13] = '{{24'h203700, 32'h0fffffce}, {24'h203800, 32'h6},
    {24'h203801, 32'h3e8}, {24'h203802, 32'h3e8}, {24'h203803, 32'h3e8}, {24'h203804, 32'h0},
    {24'h203805, 32'h0}, {24'h203806, 32'h0}, {24'h203900, 32'h4}, {24'h203901, 32'h0},
    {24'h203902, 32'h0}, {24'h203903, 32'h0}, {24'h203904, 32'h0}};
  logic [55:0] bad [8] = '{{24'h203800, 32'h1}, {24'h203901, 32'h5}, {24'h203900, 32'h4},
    {24'h203701, 32'h1}, {24'h204000, 32'h1}, {24'h203805, 32'h7d1}, {24'h203806, 32'h1},
    {24'h203806, 32'h65}};
  logic [31:0] redSet [8] = '{32'hffffffc4, 32'hffffff9c, 32'hffffffff, 32'h0, 32'h1067,
    32'h1068, 32'h64, 32'hffffff9b};
  bcrc_ctl #(.CLK_HZ(200000), .TICK_CYCLES(TICK)) uut (.clk(clk), .reset(reset),
    .clkEnable(clkEnable), .odIndex(odIndex), .odSubindex(odSubindex), .odWrite(odWrite),
    .odRead(odRead), .odWriteData(odWriteData), .odReadData(odReadData), .odAck(odAck),
    .odError(odError), .ratedCurrentSetting(rated), .motorDriveOptionWord(optWord),
    .standstillIdleTime(32'h00000002), .enableRequest(enReq), .motorStandstill(standstill),
    .closedLoopActive(closedLoop), .fieldCurrentRms(fRms), .torqueCurrentRms(qRms),
    .phaseACurrentRms(phA), .phaseBCurrentRms(phB), .currentSetpoint(setpoint),
    .reductionActive(reductionActive), .motorPowerOn(motorPowerOn), .brakeOpen(brakeOpen),
    .brakePwm(brakePwm), .operationEnabled(operationEnabled));
  bcrc_motor_model uMotor (.moving(moving), .motorPowerOn(motorPowerOn),
    .currentSetpoint(setpoint), .motorStandstill(standstill), .phaseACurrentRms(phA),
    .phaseBCurrentRms(phB));
  always #20 clk = ~clk;
  // hang guard, the full run needs about 1300 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_mismatch++;
      $display("Error %0t: run did not finish", $time);
      end_of_test();
    end
  end
  task automatic end_of_test();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("Error %0t: %s", $time, msg);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask
  task automatic od(input logic wr, input logic [23:0] at, input logic [31:0] d,
      input logic expErr);
    odIndex = at[23:8];
    odSubindex = at[7:0];
    odWriteData = d;
    odWrite = wr;
    odRead = !wr;
    step(1);
    chk(odAck === !expErr && odError === expErr, "access answer");
    rd = odReadData;
    odWrite = 1'b0;
    odRead = 1'b0;
    step(1);
  endtask
  task automatic wr_rd(input logic [7:0] sub, input logic [31:0] d);
    od(1'b1, {16'h2038, sub}, d, 1'b0);
    od(1'b0, {16'h2038, sub}, 32'h0, 1'b0);
    chk(rd === d, "read back");
  endtask
  task automatic wait_for(ref logic s, input logic val, output int k);
    k = 0;
    while (s !== val && k < 300) begin
      step(1);
      k++;
    end
  endtask
  function automatic logic [31:0] reduced(input logic [31:0] s);
    if ($signed(s) >= 0 && s < rated) return s;
    if ($signed(s) <= -1 && $signed(s) >= -100) return longint'(rated) * (int'($signed(s)) + 100) / 100;
    return rated;
  endfunction
  function automatic logic [31:0] peak(input logic [31:0] x);
    return (longint'($signed(x)) * longint'(32'h0000b505)) >>> 15;
  endfunction
  initial begin
    void'($urandom(22086));
    step(6);
    reset = 1'b0;
    foreach (defs[i]) begin
      od(1'b0, defs[i][55:32], 32'h0, 1'b0);
      chk(rd === defs[i][31:0], "reset value");
    end
    foreach (bad[i]) od(1'b1, bad[i][55:32], bad[i][31:0], 1'b1);
    od(1'b0, 24'h204000, 32'h0, 1'b1);
    chk(rd === 32'h0, "unmapped read data");
    wr_rd(8'h05, 32'h7d0);
    wr_rd(8'h06, 32'h2);
    wr_rd(8'h06, 32'h64);
    repeat (8) begin
      n = 1 + $urandom % 6;
      v = $urandom;
      if (n == 5) v = v % 2001;
      if (n == 6) v = ($urandom % 2) ? 32'h0 : 2 + v % 99;
      wr_rd(8'(n), v);
    end
    wr_rd(8'h01, 32'h3);
    wr_rd(8'h02, 32'h2);
    wr_rd(8'h03, 32'h3);
    wr_rd(8'h04, 32'h2);
    wr_rd(8'h05, 32'h3e8);
    wr_rd(8'h06, 32'h32);
    enReq = 1'b1;
    wait_for(motorPowerOn, 1'b1, n);
    chk(n <= 2 && brakeOpen === 1'b0, "power on");
    wait_for(brakeOpen, 1'b1, n);
    chk(n >= 3 * TICK && n <= 4 * TICK + 2, "open delay");
    wait_for(operationEnabled, 1'b1, n);
    chk(n >= 2 * TICK && n <= 3 * TICK + 2, "start delay");
    hi = 0;
    rises = 0;
    repeat (400) begin
      v[0] = brakePwm;
      step(1);
      hi += brakePwm;
      rises += (brakePwm && !v[0]);
    end
    // 1000 Hz at 200 kHz is 200 cycles a period, duty 50 %
    chk(hi >= 196 && hi <= 204 && rises >= 1 && rises <= 3, "pwm shape");
    od(1'b1, 24'h203805, 32'h0, 1'b0);
    step(4);
    hi = 0;
    repeat (50) begin
      step(1);
      hi += brakePwm;
    end
    chk(hi == 0, "pwm at zero frequency");
    enReq = 1'b0;
    step(60);
    chk(brakeOpen === 1'b1, "brake closed while moving");
    moving = 1'b0;
    wait_for(brakeOpen, 1'b0, n);
    chk(n >= 3 * TICK && n <= 4 * TICK + 2, "close idle");
    wait_for(motorPowerOn, 1'b0, n);
    chk(n >= 2 * TICK && n <= 3 * TICK + 2, "power off idle");
    moving = 1'b1;
    optWord = 32'h8;
    enReq = 1'b1;
    wait_for(operationEnabled, 1'b1, n);
    foreach (redSet[i]) begin
      od(1'b1, 24'h203700, redSet[i], 1'b0);
      moving = 1'b0;
      wait_for(reductionActive, 1'b1, n);
      chk(n >= 2 * TICK && n <= 3 * TICK + 3, "reduction idle");
      chk(setpoint === reduced(redSet[i]), "reduced current");
      moving = 1'b1;
      step(2);
      chk(reductionActive === 1'b0 && setpoint === rated, "reduction while moving");
    end
    clkEnable = 1'b0;
    moving = 1'b0;
    step(40);
    chk(reductionActive === 1'b0 && setpoint === rated, "state moved while frozen");
    clkEnable = 1'b1;
    optWord = 32'h0;
    moving = 1'b0;
    step(40);
    chk(reductionActive === 1'b0, "reduction without enable bit");
    moving = 1'b1;
    repeat (6) begin
      rated = $urandom % 32'h00010000;
      fRms = $urandom;
      qRms = $urandom;
      closedLoop = $urandom % 2;
      step(3);
      for (int s = 1; s <= 4; s++) begin
        od(1'b0, {16'h2039, 8'(s)}, 32'h0, 1'b0);
        v = (s == 1) ? (closedLoop ? peak(fRms) : 32'h0) : (s == 2) ? (closedLoop ? peak(qRms)
          : 32'h0) : (s == 3) ? peak(rated) : peak(-rated);
        chk(rd === v, "current reading");
      end
    end
    end_of_test();
  end
endmodule
`default_nettype wire
